/* File: src/acss_top.sv */
// Channel sequence selection, conversion sequencing and result formatting.
// Assumes all pin inputs are asynchronous; a raw sample port supplies offset-binary data.
//
// Contract
// [RULE_01] Any subset of four channels, none to all, may be chosen.
// [RULE_02] Chosen channels convert in ascending channel number order.
// [RULE_03] Source select steers a mux between pins and mask register.
// [RULE_04] Source low uses pins; source high uses the mask register.
// [RULE_05] Channel included when its pin or register bit is high at start edge.
// [RULE_06] Selection latched at start and held until the sequence ends.
// [RULE_07] Register bit 0 is channel 1 up to bit 3 is channel 4.
// [RULE_08] Low data lines are inputs while read high, select and write low.
// [RULE_09] Mask register captures data lines on write strobe rising edge.
// [RULE_10] Results are 12-bit codes, step equal to range over 4096.
// [RULE_11] Bipolar ranges use twos complement with sign in the top bit.
// [RULE_12] Bipolar: most negative is 100..0, most positive 011..1.
// [RULE_13] Unipolar ranges use straight binary from zeros to ones.
// [RULE_14] Busy rises at start edge and stays high through the sequence.
// [RULE_15] Results are read over a 12-bit bus with select and read.
// [RULE_16] Mask register holds its last written value; power-up value undefined.
`timescale 1ns/1ps
`default_nettype none
module acss_top
    import acss_pkg::*;
#(
    parameter int CONV_CYCLES = ACSS_CONV_CYCLES
) (
    input  wire logic                  i_sys_clk,
    input  wire logic                  i_nrst,
    input  wire logic [ACSS_NCHAN-1:0] i_hw_chan_pick,
    input  wire logic                  i_src_sel,
    input  wire logic                  i_conversion_trigger_n,
    input  wire logic                  i_bipolar,
    input  wire logic                  i_cs_n,
    input  wire logic                  i_rd_n,
    input  wire logic                  i_wr_n,
    input  wire logic [11:0]           i_data,
    input  wire logic [11:0]           i_raw_sample,
    output logic [11:0]                o_data,
    output logic [11:0]                o_data_oe,
    output logic                       o_busy,
    output logic                       o_eoc_n,
    output logic [1:0]                 o_conv_chan,
    output logic                       o_conv_active
);
    if (CONV_CYCLES < 1 || CONV_CYCLES > 65535) begin : g_chk
        $error("CONV_CYCLES out of range");
    end

    // Two-stage synchronisers for every pin input
    localparam int SW = 4 + 1 + 1 + 1 + 3 + 12;
    logic [SW-1:0] sync1_r;
    logic [SW-1:0] sync2_r;
    logic [SW-1:0] sync_in;
    assign sync_in = {i_hw_chan_pick, i_src_sel, i_conversion_trigger_n, i_bipolar,
                      i_cs_n, i_rd_n, i_wr_n, i_data};
    always_ff @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            sync1_r <= '1;
            sync2_r <= '1;
        end else begin
            sync1_r <= sync_in;
            sync2_r <= sync1_r;
        end
    end

    logic [3:0]  pick_s;
    logic        src_s;
    logic        trig_n_s;
    logic        bip_s;
    acss_bus_t   bus_s;
    logic [11:0] data_s;
    assign {pick_s, src_s, trig_n_s, bip_s, bus_s, data_s} = sync2_r;

    // Edge history for trigger and write strobe
    logic trig_d_r;
    logic wr_d_r;
    always_ff @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            trig_d_r <= 1'b1;
            wr_d_r   <= 1'b1;
        end else begin
            trig_d_r <= trig_n_s;
            wr_d_r   <= bus_s.wr_n;
        end
    end
    logic start_edge;
    logic wr_rise;
    assign start_edge = trig_n_s & ~trig_d_r;

    // Write cycle is valid only while read is high and select low
    logic wr_window_r;
    assign wr_rise = bus_s.wr_n & ~wr_d_r & wr_window_r; // [RULE_09]

    // Lowest set bit of a mask; shared by first-channel and next-channel picks
    function automatic logic [1:0] acss_lowest(input logic [3:0] m);
        logic [1:0] idx;
        idx = 2'd0;
        for (int k = ACSS_NCHAN - 1; k >= 0; k--) begin
            if (m[k]) begin
                idx = 2'(k);
            end
        end
        return idx;
    endfunction

    // Mask register, written from the low data lines
    logic [3:0] mask_r;
    logic [3:0] mask_nxt;
    logic       wr_window_nxt;
    always_comb begin
        wr_window_nxt = ~bus_s.cs_n & ~bus_s.wr_n & bus_s.rd_n; // [RULE_08]
        mask_nxt      = mask_r; // [RULE_16]
        if (wr_rise) begin
            mask_nxt = data_s[3:0]; // [RULE_07]
        end
    end
    always_ff @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            mask_r      <= ACSS_MASK_RST;
            wr_window_r <= 1'b0;
        end else begin
            mask_r      <= mask_nxt;
            wr_window_r <= wr_window_nxt;
        end
    end

    // Selection source mux
    logic [3:0] sel_mux;
    assign sel_mux = (src_s == ACSS_SRC_REG) ? mask_r : pick_s; // [RULE_03] [RULE_04]

    // Sequencer
    acss_state_t state_r;
    acss_state_t state_nxt;
    logic [3:0]  pend_r;
    logic [3:0]  pend_nxt;
    logic [1:0]  chan_r;
    logic [1:0]  chan_nxt;
    logic [15:0] cnt_r;
    logic [15:0] cnt_nxt;
    logic        busy_r;
    logic        busy_nxt;
    logic        eoc_n_r;
    logic        eoc_n_nxt;
    logic [11:0] res_r;
    logic [11:0] res_nxt;
    logic        bip_r;
    logic        bip_nxt;
    logic        conv_active_r;
    logic        conv_active_nxt;
    logic [3:0]  rest;
    always_comb begin
        state_nxt = state_r;
        pend_nxt  = pend_r;
        chan_nxt  = chan_r;
        cnt_nxt   = cnt_r;
        busy_nxt  = busy_r;
        eoc_n_nxt = 1'b1;
        res_nxt   = res_r;
        bip_nxt   = bip_r;
        rest      = pend_r & ~(4'h1 << chan_r);
        unique case (state_r)
            ACSS_IDLE: begin
                if (start_edge) begin
                    pend_nxt = sel_mux; // [RULE_05] [RULE_06] [RULE_01]
                    bip_nxt  = bip_s;
                    busy_nxt = 1'b1; // [RULE_14]
                    chan_nxt = acss_lowest(sel_mux); // [RULE_02]
                    cnt_nxt  = 16'(CONV_CYCLES - 1);
                    if (sel_mux != 4'h0) begin
                        state_nxt = ACSS_CONV;
                    end else begin
                        state_nxt = ACSS_NEXT;
                    end
                end
            end
            ACSS_CONV: begin
                if (cnt_r == 16'h0000) begin
                    // Mid-tread code from offset-binary sample, step is range/4096
                    res_nxt   = bip_r ? (i_raw_sample ^ ACSS_SIGN_FLIP) : i_raw_sample; // [RULE_10] [RULE_11] [RULE_12] [RULE_13]
                    eoc_n_nxt = 1'b0;
                    pend_nxt  = rest;
                    state_nxt = ACSS_NEXT;
                end else begin
                    cnt_nxt = cnt_r - 16'h0001;
                end
            end
            ACSS_NEXT: begin
                if (pend_r == 4'h0) begin
                    busy_nxt  = 1'b0; // [RULE_14]
                    state_nxt = ACSS_IDLE;
                end else begin
                    chan_nxt  = acss_lowest(pend_r); // [RULE_02]
                    cnt_nxt   = 16'(CONV_CYCLES - 1);
                    state_nxt = ACSS_CONV;
                end
            end
        endcase
        // Registered copy of the converting state so the output leaves a flop
        conv_active_nxt = (state_nxt == ACSS_CONV); // [RULE_02]
    end
    always_ff @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            state_r <= ACSS_IDLE;
            pend_r  <= 4'h0;
            chan_r  <= 2'd0;
            cnt_r   <= 16'h0000;
            busy_r  <= 1'b0;
            eoc_n_r <= 1'b1;
            res_r   <= ACSS_RES_RST;
            bip_r   <= 1'b0;
            conv_active_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            pend_r  <= pend_nxt;
            chan_r  <= chan_nxt;
            cnt_r   <= cnt_nxt;
            busy_r  <= busy_nxt;
            eoc_n_r <= eoc_n_nxt;
            res_r   <= res_nxt;
            bip_r   <= bip_nxt;
            conv_active_r <= conv_active_nxt;
        end
    end

    // Result read port; drives only while select and read are both low
    logic [11:0] dout_r;
    logic [11:0] oe_r;
    always_ff @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            dout_r <= ACSS_RES_RST;
            oe_r   <= 12'h000;
        end else begin
            dout_r <= res_nxt; // [RULE_15]
            oe_r   <= {12{~bus_s.cs_n & ~bus_s.rd_n}}; // [RULE_15]
        end
    end

    assign o_data        = dout_r;
    assign o_data_oe     = oe_r;
    assign o_busy        = busy_r;
    assign o_eoc_n       = eoc_n_r;
    assign o_conv_chan   = chan_r;
    assign o_conv_active = conv_active_r;
endmodule // acss_top
`default_nettype wire

/* File: src/acss_pkg.sv */
// Package for the channel sequence select and result formatting block.
// Assumes a single 250 MHz system clock domain.
package acss_pkg;
    localparam int          ACSS_NCHAN        = 4;
    localparam int          ACSS_RES_W        = 12;
    localparam int          ACSS_CODE_STEPS   = 4096;
    // Per-channel conversion time in ns and derived cycle count (longest, rounds down)
    localparam int          ACSS_CONV_TIME_NS = 1650;
    localparam int          ACSS_CLK_PERIOD_NS = 4;
    localparam int          ACSS_CONV_CYCLES  = ACSS_CONV_TIME_NS / ACSS_CLK_PERIOD_NS;
    localparam logic [3:0]  ACSS_MASK_RST     = 4'h0;
    localparam logic [11:0] ACSS_RES_RST      = 12'h000;
    localparam logic [11:0] ACSS_SIGN_FLIP    = 12'h800;
    localparam logic        ACSS_SRC_PINS     = 1'b0;
    localparam logic        ACSS_SRC_REG      = 1'b1;

    // Bus strobes that travel together
    typedef struct packed {
        logic cs_n;
        logic rd_n;
        logic wr_n;
    } acss_bus_t;

    typedef enum logic [1:0] {
        ACSS_IDLE,
        ACSS_CONV,
        ACSS_NEXT
    } acss_state_t;
endpackage

/* File: tb/acss_properties.sv */
// Checker for the sequence select block, bound to its top module.
// Assumes one clock domain and a testbench that holds raw and bipolar steady per sequence.
`timescale 1ns/1ps
`default_nettype none
module acss_properties
    import acss_pkg::*;
#(
    parameter int CONV_CYCLES = ACSS_CONV_CYCLES
) (
    input wire logic        i_sys_clk,
    input wire logic        i_nrst,
    input wire logic        i_cs_n,
    input wire logic        i_rd_n,
    input wire logic        i_bipolar,
    input wire logic [11:0] i_raw_sample,
    input wire logic [11:0] o_data,
    input wire logic [11:0] o_data_oe,
    input wire logic        o_busy,
    input wire logic        o_eoc_n,
    input wire logic        o_conv_active
);
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (!i_nrst);
    // Read held long enough to pass the input synchronisers
    sequence rd_held; (!i_cs_n && !i_rd_n) [*4]; endsequence
    sequence eoc_gap; o_eoc_n [*3]; endsequence
    eoc_busy_a: assert property (!o_eoc_n |-> o_busy) else $error("eoc outside busy");
    act_busy_a: assert property (o_conv_active |-> o_busy) else $error("active, not busy");
    // A start with channels goes straight to converting; an empty one ends at once
    sequence rise_conv; $rose(o_busy) && o_conv_active; endsequence
    busy_min_a: assert property (rise_conv |-> o_busy [*2])
        else $error("busy short");
    busy_ends_a: assert property (rise_conv |-> ##[2:60] !o_busy)
        else $error("busy stuck");
    busy_empty_a: assert property ($rose(o_busy) && !o_conv_active |=> !o_busy)
        else $error("empty busy long");
    eoc_pulse_a: assert property ($fell(o_eoc_n) |=> eoc_gap) else $error("eoc too long");
    oe_read_a: assert property (rd_held |-> o_data_oe == 12'hfff) else $error("no drive");
    oe_idle_a: assert property (i_rd_n [*4] |-> o_data_oe == 12'h000) else $error("drive");
    // Bipolar flips the sign bit of the offset-binary sample
    code_fmt_a: assert property (!o_eoc_n |-> o_data == (i_raw_sample ^
        (i_bipolar ? ACSS_SIGN_FLIP : ACSS_RES_RST))) else $error("bad code");
endmodule // acss_properties
bind acss_top acss_properties #(.CONV_CYCLES(CONV_CYCLES)) u_props (
    .i_sys_clk(i_sys_clk), .i_nrst(i_nrst), .i_cs_n(i_cs_n), .i_rd_n(i_rd_n),
    .i_bipolar(i_bipolar), .i_raw_sample(i_raw_sample), .o_data(o_data),
    .o_data_oe(o_data_oe), .o_busy(o_busy), .o_eoc_n(o_eoc_n),
    .o_conv_active(o_conv_active));
`default_nettype wire

/* File: tb/acss_host.sv */
// Host processor model driving bus strobes, data lines and the start pin.
// Assumes the testbench resolves the shared data lines from the block's output enable.
`timescale 1ns/1ps
`default_nettype none
module acss_host
    import acss_pkg::*;
(
    input  wire logic        i_sys_clk,
    input  wire logic [11:0] i_data,
    input  wire logic [11:0] i_data_oe,
    output var  acss_bus_t   o_bus,
    output var  logic [11:0] o_data,
    output var  logic        o_trig_n
);
    // Idle bus, strobes inactive
    initial begin
        o_bus = '1;
        o_data = 12'h000;
        o_trig_n = 1'b1;
    end
    // Mask write; data held past the strobe rise for the synchronisers
    task automatic write_mask(input logic [3:0] m);
        @(negedge i_sys_clk);
        o_data = {8'h00, m};
        o_bus = 3'b010;
        repeat (4) @(negedge i_sys_clk);
        o_bus = '1;
        repeat (4) @(negedge i_sys_clk);
        o_data = ~o_data; // Released lines show no stale value
    endtask
    // Start pulse; the rising edge takes the selection
    task automatic start();
        @(negedge i_sys_clk);
        o_trig_n = 1'b0;
        repeat (3) @(negedge i_sys_clk);
        o_trig_n = 1'b1;
    endtask
    // Bounded read of one result word
    task automatic read_word(output logic [11:0] w, output logic ok);
        ok = 1'b0;
        o_bus = 3'b001;
        for (int t = 0; t < 9 && !ok; t++) begin
            @(negedge i_sys_clk);
            ok = (i_data_oe === 12'hfff);
        end
        w = i_data;
        repeat (2) @(negedge i_sys_clk);
        o_bus = '1;
    endtask
endmodule // acss_host
`default_nettype wire

/* File: tb/acss_top_tb.sv */
// Self-checking bench for the sequence select block.
// Assumes the short conversion count of 4 cycles per channel.
`timescale 1ns/1ps
`default_nettype none
module acss_top_tb
    import acss_pkg::*;
;
    typedef struct packed {
        logic s; logic [3:0] p; logic [3:0] m; logic b; logic [11:0] raw; logic [11:0] exp;
    } acss_row_t;
    // Source, pins, mask, bipolar, sample, expected code
    acss_row_t rows [5] = '{'{1'b0, 4'hd, 4'h2, 1'b1, 12'h000, 12'h800},
        '{1'b1, 4'h2, 4'hb, 1'b0, 12'hfff, 12'hfff}, '{1'b1, 4'hf, 4'h0, 1'b1, 12'h7ff, 12'hfff},
        '{1'b0, 4'hf, 4'h5, 1'b1, 12'hfff, 12'h7ff}, '{1'b1, 4'h0, 4'hf, 1'b0, 12'h5a3, 12'h5a3}};
    logic i_sys_clk = 0, i_nrst = 0, src = 0, bip = 0, busy, eoc_n, act, trig_n, ok;
    logic [3:0]  pick = 4'h0;
    logic [1:0]  chan;
    logic [11:0] raw = 12'h000, h_d, d_out, oe, bus_d, w;
    acss_bus_t   bus;
    int          fail_count = 0, checked = 0;
    always #2 i_sys_clk = ~i_sys_clk;
    // Shared data lines: the driving party wins per bit
    assign bus_d = (oe & d_out) | (~oe & h_d);
    acss_top #(.CONV_CYCLES(4)) i_acss_top (.i_sys_clk(i_sys_clk), .i_nrst(i_nrst),
        .i_hw_chan_pick(pick), .i_src_sel(src), .i_conversion_trigger_n(trig_n),
        .i_bipolar(bip), .i_cs_n(bus.cs_n), .i_rd_n(bus.rd_n), .i_wr_n(bus.wr_n),
        .i_data(bus_d), .i_raw_sample(raw), .o_data(d_out), .o_data_oe(oe), .o_busy(busy),
        .o_eoc_n(eoc_n), .o_conv_chan(chan), .o_conv_active(act));
    acss_host i_acss_host (.i_sys_clk(i_sys_clk), .i_data(bus_d), .i_data_oe(oe),
        .o_bus(bus), .o_data(h_d), .o_trig_n(trig_n));
    task automatic check(input string nm, input logic [11:0] got, input logic [11:0] exp);
        checked++;
        if (got !== exp) begin
            fail_count++;
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic conclude();
        $display("checked %0d mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    // One sequence; selection sources are disturbed after the start to prove the latch
    task automatic run_row(input acss_row_t r);
        int c, n, t, na;
        logic hi;
        logic [3:0] sel;
        c = 0; n = 0; hi = 0; na = 0;
        sel = r.s ? r.m : r.p;
        src = r.s; pick = r.p; bip = r.b; raw = r.raw;
        i_acss_host.write_mask(r.m);
        i_acss_host.start();
        fork
            begin repeat (6) @(negedge i_sys_clk); pick = ~r.p; end
            if (r.s) i_acss_host.write_mask(~r.m);
            for (t = 0; t < 99 && (t < 6 || busy); t++) begin
                @(negedge i_sys_clk);
                hi |= busy;
                if (act === 1'b1) na++;
                if (eoc_n === 1'b0) begin
                    while (c < 4 && !sel[c]) c++;
                    check("chan", {10'h000, chan}, 12'(c));
                    check("code", d_out, r.exp);
                    c++; n++;
                end
            end
        join
        check("count", 12'(n), 12'($countones(sel)));
        // Four converting cycles per chosen channel at the bench's short count
        check("active", 12'(na), 12'(4 * $countones(sel)));
        check("busy", {11'h000, hi}, 12'h001);
        if (t >= 99) begin fail_count++; conclude(); end
        $display("sequence row done");
    endtask
    // Rows, then readback and a reset in mid-sequence
    initial begin
        repeat (2) @(negedge i_sys_clk);
        i_nrst = 1;
        repeat (3) @(negedge i_sys_clk);
        foreach (rows[i]) run_row(rows[i]);
        i_acss_host.read_word(w, ok);
        check("read", w, 12'h5a3);
        check("oe", {11'h000, ok}, 12'h001);
        $display("readback done");
        // Pins pick all four so the reset really lands inside a running sequence
        src = 1'b0; pick = 4'hf;
        i_acss_host.start();
        repeat (6) @(negedge i_sys_clk);
        check("midbusy", {11'h000, busy}, 12'h001);
        i_nrst = 0;
        @(negedge i_sys_clk);
        check("reset", {9'h000, busy, eoc_n, oe[0]}, 12'h002);
        i_nrst = 1;
        $display("reset done");
        conclude();
    end
endmodule // acss_top_tb
`default_nettype wire
